// ---- include/dds_consts.vh ----
`ifndef DDS_CONSTS_VH
`define DDS_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DDS_OFF_CTRL 8'h00
`define DDS_OFF_STATUS 8'h04
`define DDS_OFF_IRQ_STAT 8'h08
`define DDS_OFF_IRQ_MASK 8'h0c
`define DDS_OFF_TEMP 8'h10
`define DDS_OFF_THERM 8'h14
`define DDS_OFF_SAVED 8'h18

// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define DDS_CTRL_PARK_RPT 0
`define DDS_CTRL_INT_REV 1
`define DDS_CTRL_TOGGLE 2
`define DDS_CTRL_STORE 3
`define DDS_CTRL_AUX_LO 4
`define DDS_CTRL_AUX_HI 7
`define DDS_CTRL_DLY_LO 8
`define DDS_CTRL_DLY_HI 10
`define DDS_CTRL_RST 11'h10a
`define DDS_THERM_RST 12'h318
`define DDS_AUX_TEMP_FN 4'h3
`define DDS_DLY_MAX 3'h5

// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define DDS_IRQ_JAM 0
`define DDS_IRQ_AUX 1
`define DDS_IRQ_SLOW 2
`define DDS_IRQ_STOP 3
`define DDS_IRQ_SAVE 4
`define DDS_IRQ_W 5

// ----------------------------------------
// temperature in 1/16 degree units
// ----------------------------------------
`define DDS_T_AMBIENT 16'h0190
`define DDS_T_AUX 16'h0550
`define DDS_T_SLOW 16'h05f0
`define DDS_T_STOP 16'h06e0
`define DDS_T_RECOVER 16'h04b0

// ----------------------------------------
// timing
// ----------------------------------------
`define DDS_CLK_NS 20
`define DDS_TICK_NS 1000000
`define DDS_TICK_CYC (`DDS_TICK_NS / `DDS_CLK_NS)
`define DDS_SEC_MS 1000
`define DDS_SAVE_MIN 30
`define DDS_SAVE_S (`DDS_SAVE_MIN * 60)
`define DDS_RETRY_S 3'h1
`define DDS_RETRY_MAX 2'h3
`define DDS_WARN_JAM 4'h3

// ----------------------------------------
// bus answers
// ----------------------------------------
`define DDS_RESP_OK 2'h0
`define DDS_RESP_ERR 2'h2

`endif

// ---- testbench/dds_lift_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module dds_lift_ctrl (
    input wire logic i_clk,
    input wire logic [2:0] i_act,
    output var logic o_dcc,
    output var logic o_detector_contact_in,
    output var logic o_rvc
);
    // ----------------------------------------
    // lift controller pins
    // ----------------------------------------
    // pins move only after an edge, like a registered controller output
    always @(posedge i_clk) begin
        {o_dcc, o_detector_contact_in, o_rvc} <= i_act;
    end
endmodule // dds_lift_ctrl
`default_nettype wire

// ---- testbench/dds_supervisor_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module dds_supervisor_properties (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_s_axi_awvalid,
    input wire logic o_s_axi_awready,
    input wire logic i_s_axi_wvalid,
    input wire logic o_s_axi_wready,
    input wire logic o_s_axi_bvalid,
    input wire logic i_s_axi_arvalid,
    input wire logic o_s_axi_arready,
    input wire logic o_s_axi_rvalid,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic [1:0] o_s_axi_rresp,
    input wire logic i_s_axi_rready,
    input wire logic o_clutch_jam_warning,
    input wire logic [3:0] o_warning_code,
    input wire logic o_nv_write
);
    // ----------------------------------------
    // bus and status relations
    // ----------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    chk_warn_code: assert property (
        o_warning_code == (o_clutch_jam_warning ? 4'h3 : 4'h0))
        else $error("warning code not tied to jam warning");
    chk_nv_pulse: assert property (o_nv_write |=> !o_nv_write)
        else $error("nv write longer than one cycle");
    chk_aw_busy: assert property (i_s_axi_awvalid && o_s_axi_awready |=> !o_s_axi_awready)
        else $error("awready back before response");
    chk_b_answer: assert property (i_s_axi_awvalid && o_s_axi_awready
        && i_s_axi_wvalid && o_s_axi_wready |=> ##1 o_s_axi_bvalid)
        else $error("no write response two cycles after take");
    chk_r_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
        else $error("no read data one cycle after take");
    chk_ar_busy: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
        else $error("arready back before read handshake");
    // read data must not move while the master stalls
    chk_r_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready
        |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
        else $error("read data dropped or changed while stalled");
    chk_err_zero: assert property (o_s_axi_rvalid && o_s_axi_rresp == 2'h2 |-> o_s_axi_rdata == 32'h0)
        else $error("error read with nonzero data");
    cover property (o_nv_write);
    cover property (o_clutch_jam_warning);
    cover property (o_s_axi_rvalid && o_s_axi_rresp == 2'h2);
endmodule // dds_supervisor_properties
bind dds_supervisor dds_supervisor_properties chk_u (.*);
`default_nettype wire

// ---- testbench/dds_supervisor_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module dds_supervisor_tb_top;
    // ----------------------------------------
    // bench
    // ----------------------------------------
    logic i_clk, i_rst_b, i_parked_open, i_door_closed, i_reopen_done, i_reopen_full;
    logic i_unlock_req, i_lock_req, i_clutch_done, i_clutch_jam, irq0;
    logic i_detector_contact_in, i_reversing_command_in, i_door_close_command;
    logic [11:0] i_motor_current;
    logic [15:0] i_nv_temp, o_nv_wdata;
    logic [7:0] i_s_axi_awaddr, i_s_axi_araddr;
    logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rdat;
    logic [3:0] i_s_axi_wstrb, o_warning_code;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp, brsp, rrsp;
    logic i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
    logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic o_reversing_status_out, o_door_closed_status_out, o_close_enable, o_clutch_drive;
    logic o_clutch_lock, o_clutch_jam_warning, o_auxiliary_output, o_speed_reduce;
    logic o_door_stop, o_nv_write, o_irq;
    logic [2:0] act;
    int err_total, cmp_count, cyc;
    // rows: report setting, parked, close/detector/reversing pins, expected status
    localparam logic [5:0] ROWS [5] = '{6'h14, 6'h1d, 6'h33, 6'h30, 6'h0d};

    dds_supervisor #(.TICK_CYC(10), .SEC_MS(4), .SAVE_S(3)) dut_u (.*);
    dds_lift_ctrl lift_u (.i_clk(i_clk), .i_act(act), .o_dcc(i_door_close_command),
        .o_detector_contact_in(i_detector_contact_in), .o_rvc(i_reversing_command_in));

    always #10 i_clk = ~i_clk;

    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task final_report;
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // a hang ends in the same report
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            final_report();
        end
    end

    task rst;
        i_rst_b <= 1'h0;
        repeat (4) @(posedge i_clk);
        i_rst_b <= 1'h1;
        repeat (3) @(posedge i_clk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= d;
        i_s_axi_awvalid <= 1'h1;
        i_s_axi_wvalid <= 1'h1;
        do begin
            @(posedge i_clk);
            if (o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
            if (o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
        end while (!o_s_axi_bvalid);
        brsp = o_s_axi_bresp;
    endtask

    // rready comes a cycle late so the slave must hold its answer
    task rd(input logic [7:0] a);
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'h1;
        do begin
            @(posedge i_clk);
            if (o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
        end while (!o_s_axi_rvalid);
        i_s_axi_rready <= 1'h1;
        @(posedge i_clk);
        rdat = o_s_axi_rdata;
        rrsp = o_s_axi_rresp;
        i_s_axi_rready <= 1'h0;
    endtask

    task reo(input int dly, input logic full, input logic low);
        wr(8'h00, 32'h00a | (dly << 8));
        act <= 3'h4;
        repeat (8) @(posedge i_clk);
        i_reopen_full <= full;
        i_reopen_done <= 1'h1;
        @(posedge i_clk);
        i_reopen_done <= 1'h0;
        repeat (4) @(posedge i_clk);
        chk("close", o_close_enable, !low);
        repeat (dly * 40 - 16) @(posedge i_clk);
        chk("close", o_close_enable, !low);
        repeat (32) @(posedge i_clk);
        chk("close", o_close_enable, 32'h1);
        act <= 3'h0;
    endtask

    task cl(input logic dir, input logic tog);
        wr(8'h00, 32'h10a | (tog << 2));
        i_door_closed <= !tog;
        if (dir) i_lock_req <= 1'h1;
        else i_unlock_req <= 1'h1;
        @(posedge i_clk);
        i_lock_req <= 1'h0;
        i_unlock_req <= 1'h0;
        repeat (3) @(posedge i_clk);
        chk("lock", o_clutch_lock, dir);
        for (int k = 0; k < 4; k++) begin
            i_clutch_jam <= 1'h1;
            @(posedge i_clk);
            i_clutch_jam <= 1'h0;
            repeat (3) @(posedge i_clk);
            chk("warn", o_warning_code, 32'h3);
            if (k < 3) begin
                chk("lock", o_clutch_lock, !dir);
                i_clutch_done <= 1'h1;
                @(posedge i_clk);
                i_clutch_done <= 1'h0;
                repeat (10) @(posedge i_clk);
                if (!dir) chk("dcs", o_door_closed_status_out, tog);
                repeat (48) @(posedge i_clk);
                chk("lock", o_clutch_lock, dir);
            end
        end
        chk("lock", o_clutch_lock, dir);
        chk("drive", o_clutch_drive, 32'h0);
        i_door_closed <= 1'h0;
    endtask

    initial begin
        {i_clk, i_parked_open, i_door_closed, i_reopen_done, i_reopen_full} = 5'h0;
        {i_unlock_req, i_lock_req, i_clutch_done, i_clutch_jam, act} = 7'h0;
        {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = 3'h1;
        {i_s_axi_arvalid, i_s_axi_rready, i_s_axi_awaddr, i_s_axi_araddr} = 18'h0;
        {i_s_axi_wdata, i_s_axi_wstrb, i_motor_current} = 48'hf000;
        i_nv_temp = 16'h0190;
        {err_total, cmp_count, cyc} = 96'h0;
        rst();
        rd(8'h00);
        chk("ctrl", rdat, 32'h10a);
        rd(8'h40);
        chk("rresp", rrsp, 32'h2);
        chk("rdata", rdat, 32'h0);
        wr(8'h42, 32'h1);
        chk("bresp", brsp, 32'h2);
        for (int i = 0; i < 5; i++) begin
            wr(8'h00, 32'h10a | ROWS[i][5]);
            i_parked_open <= ROWS[i][4];
            act <= ROWS[i][3:1];
            repeat (8) @(posedge i_clk);
            chk("rvs", o_reversing_status_out, ROWS[i][0]);
        end
        act <= 3'h0;
        i_parked_open <= 1'h0;
        reo(1, 1'h1, 1'h1);
        reo(1, 1'h0, 1'h0);
        reo(0, 1'h1, 1'h0);
        reo(5, 1'h1, 1'h1);
        cl(1'h0, 1'h0);
        rd(8'h08);
        chk("jam irq", rdat[0], 32'h1);
        wr(8'h0c, 32'h0);
        repeat (2) @(posedge i_clk);
        irq0 = o_irq;
        wr(8'h0c, 32'h1f);
        repeat (2) @(posedge i_clk);
        chk("irq mask", irq0 ^ o_irq, 32'h1);
        wr(8'h08, 32'h1);
        rd(8'h08);
        chk("irq clear", rdat[0], 32'h0);
        cl(1'h0, 1'h1);
        cl(1'h1, 1'h0);
        @(posedge i_clk iff o_nv_write);
        chk("nv", o_nv_wdata, 32'h190);
        i_nv_temp <= 16'h06f0;
        rst();
        repeat (15) @(posedge i_clk);
        chk("stop", o_door_stop, 32'h1);
        chk("slow", o_speed_reduce, 32'h1);
        chk("aux", o_auxiliary_output, 32'h0);
        wr(8'h00, 32'h13a);
        repeat (3) @(posedge i_clk);
        chk("aux", o_auxiliary_output, 32'h1);
        repeat (20) @(posedge i_clk);
        chk("aux", o_auxiliary_output, 32'h0);
        chk("slow", o_speed_reduce, 32'h0);
        chk("stop", o_door_stop, 32'h1);
        rst();
        wr(8'h00, 32'h102);
        repeat (15) @(posedge i_clk);
        rd(8'h10);
        chk("temp", rdat, 32'h190);
        chk("stop", o_door_stop, 32'h0);
        final_report();
    end
endmodule // dds_supervisor_tb_top
`default_nettype wire

// ---- verilog/dds_supervisor.v ----
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dds_consts.vh"

// How it works
// - report 00: parked open alone gives no reversing status
// - report 00: source plus close command reports at once
// - report 01: parked open reports every reversing source
// - full reopen waits reclose delay before closing
// - partial reopen closes with no delay
// - delay 00 off, 01..05 seconds, default one
// - opening jam: relock, warn, retry, three retries
// - closing jam: unlock, warn, retry, three retries
// - toggle 00: closed status inactive during unlock retries
// - toggle 01: inactive opening clutch, active reclosing
// - storage off: temperature starts at 25 C
// - storage on: save every 30 min, restore
// - temperature estimated from current, resistance, capacity
// - above 85 C aux output when function 3
// - above 95 C reduce speed both directions
// - above 110 C stop until back at 75 C
// - clutch jam reports warning code three
module dds_supervisor #(
    parameter TICK_CYC = `DDS_TICK_CYC,
    parameter SEC_MS = `DDS_SEC_MS,
    parameter SAVE_S = `DDS_SAVE_S
) (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_detector_contact_in,
    input wire i_reversing_command_in,
    input wire i_door_close_command,
    input wire i_parked_open,
    input wire i_door_closed,
    input wire i_reopen_done,
    input wire i_reopen_full,
    input wire i_unlock_req,
    input wire i_lock_req,
    input wire i_clutch_done,
    input wire i_clutch_jam,
    input wire [11:0] i_motor_current,
    input wire [15:0] i_nv_temp,
    input wire [7:0] i_s_axi_awaddr,
    input wire i_s_axi_awvalid,
    output reg o_s_axi_awready,
    input wire [31:0] i_s_axi_wdata,
    input wire [3:0] i_s_axi_wstrb,
    input wire i_s_axi_wvalid,
    output reg o_s_axi_wready,
    output reg [1:0] o_s_axi_bresp,
    output reg o_s_axi_bvalid,
    input wire i_s_axi_bready,
    input wire [7:0] i_s_axi_araddr,
    input wire i_s_axi_arvalid,
    output reg o_s_axi_arready,
    output reg [31:0] o_s_axi_rdata,
    output reg [1:0] o_s_axi_rresp,
    output reg o_s_axi_rvalid,
    input wire i_s_axi_rready,
    output reg o_reversing_status_out,
    output reg o_door_closed_status_out,
    output reg o_close_enable,
    output reg o_clutch_drive,
    output reg o_clutch_lock,
    output reg o_clutch_jam_warning,
    output reg [3:0] o_warning_code,
    output reg o_auxiliary_output,
    output reg o_speed_reduce,
    output reg o_door_stop,
    output reg o_nv_write,
    output reg [15:0] o_nv_wdata,
    output reg o_irq
);

    localparam ST_IDLE = 3'h0;
    localparam ST_MOVE = 3'h1;
    localparam ST_BACK = 3'h2;
    localparam ST_WAIT = 3'h3;
    localparam ST_STOP = 3'h4;

    // word decode shared by read and write paths
    function [2:0] reg_idx;
        input [7:0] addr;
        begin
            reg_idx = addr[4:2];
        end
    endfunction

    function mapped;
        input [7:0] addr;
        begin
            mapped = (addr[7:5] == 3'h0) && (addr[4:2] != 3'h7) && (addr[1:0] == 2'h0);
        end
    endfunction

    // ----------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------
    reg [1:0] rst_sync_reg;
    wire rst_b = rst_sync_reg[1];
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) rst_sync_reg <= 2'h0;
        else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    reg [2:0] pin_meta_reg;
    reg [2:0] pin_reg;
    always @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta_reg <= 3'h0;
            pin_reg <= 3'h0;
        end else begin
            pin_meta_reg <= {i_door_close_command, i_reversing_command_in, i_detector_contact_in};
            pin_reg <= pin_meta_reg;
        end
    end
    wire rev_src = pin_reg[0] | pin_reg[1];
    wire dcc = pin_reg[2];

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [10:0] ctrl_reg;
    reg [11:0] therm_reg;
    reg [`DDS_IRQ_W-1:0] irq_stat_reg;
    reg [`DDS_IRQ_W-1:0] irq_mask_reg;
    reg [15:0] temp_reg;
    reg [15:0] saved_reg;
    reg [2:0] cl_state_reg;
    reg [1:0] retry_reg;
    reg cl_target_reg;
    wire park_rpt = ctrl_reg[`DDS_CTRL_PARK_RPT];
    wire int_rev = ctrl_reg[`DDS_CTRL_INT_REV];
    wire toggle = ctrl_reg[`DDS_CTRL_TOGGLE];
    wire store_en = ctrl_reg[`DDS_CTRL_STORE];
    wire [3:0] aux_fn = ctrl_reg[`DDS_CTRL_AUX_HI:`DDS_CTRL_AUX_LO];
    wire [2:0] dly_s = ctrl_reg[`DDS_CTRL_DLY_HI:`DDS_CTRL_DLY_LO];

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    reg aw_held_reg;
    reg w_held_reg;
    reg [7:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    wire aw_take = i_s_axi_awvalid & o_s_axi_awready;
    wire w_take = i_s_axi_wvalid & o_s_axi_wready;
    wire wr_go = aw_held_reg & w_held_reg & ~o_s_axi_bvalid;
    wire wr_hit = wr_go & mapped(awaddr_reg);
    wire [2:0] wr_idx = reg_idx(awaddr_reg);
    wire ar_take = i_s_axi_arvalid & o_s_axi_arready;
    reg [`DDS_IRQ_W-1:0] irq_set;
    reg [31:0] rd_word;

    always @* begin
        case (reg_idx(i_s_axi_araddr))
            3'h0: rd_word = {21'h0, ctrl_reg};
            3'h1: rd_word = {22'h0, retry_reg, cl_state_reg, o_door_stop, o_speed_reduce,
                             o_auxiliary_output, o_door_closed_status_out,
                             o_reversing_status_out};
            3'h2: rd_word = {27'h0, irq_stat_reg};
            3'h3: rd_word = {27'h0, irq_mask_reg};
            3'h4: rd_word = {16'h0, temp_reg};
            3'h5: rd_word = {20'h0, therm_reg};
            3'h6: rd_word = {16'h0, saved_reg};
            default: rd_word = 32'h0;
        endcase
    end

    always @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready <= 1'b1;
            o_s_axi_arready <= 1'b1;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= `DDS_RESP_OK;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rresp <= `DDS_RESP_OK;
            o_s_axi_rdata <= 32'h0;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            ctrl_reg <= `DDS_CTRL_RST;
            therm_reg <= `DDS_THERM_RST;
            irq_mask_reg <= {`DDS_IRQ_W{1'b0}};
            irq_stat_reg <= {`DDS_IRQ_W{1'b0}};
            o_irq <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= i_s_axi_awaddr;
                o_s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                wdata_reg <= i_s_axi_wdata;
                wstrb_reg <= i_s_axi_wstrb;
                o_s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp <= mapped(awaddr_reg) ? `DDS_RESP_OK : `DDS_RESP_ERR;
            end
            if (o_s_axi_bvalid & i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
                o_s_axi_awready <= 1'b1;
                o_s_axi_wready <= 1'b1;
            end
            if (wr_hit & (wr_idx == 3'h0)) begin
                if (wstrb_reg[0]) ctrl_reg[7:0] <= wdata_reg[7:0];
                if (wstrb_reg[1]) begin
                    // out of range delays clamp to the longest setting
                    ctrl_reg[10:8] <= (wdata_reg[10:8] > `DDS_DLY_MAX) ? `DDS_DLY_MAX
                                                                        : wdata_reg[10:8];
                end
            end
            if (wr_hit & (wr_idx == 3'h3) & wstrb_reg[0]) irq_mask_reg <= wdata_reg[4:0];
            if (wr_hit & (wr_idx == 3'h5)) begin
                if (wstrb_reg[0]) therm_reg[7:0] <= wdata_reg[7:0];
                if (wstrb_reg[1]) therm_reg[11:8] <= wdata_reg[11:8];
            end
            // a new event wins over a write-one clear in the same cycle
            if (wr_hit & (wr_idx == 3'h2) & wstrb_reg[0])
                irq_stat_reg <= (irq_stat_reg & ~wdata_reg[4:0]) | irq_set;
            else
                irq_stat_reg <= irq_stat_reg | irq_set;
            o_irq <= |((irq_stat_reg | irq_set) & irq_mask_reg);
            if (ar_take) begin
                o_s_axi_arready <= 1'b0;
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rdata <= mapped(i_s_axi_araddr) ? rd_word : 32'h0;
                o_s_axi_rresp <= mapped(i_s_axi_araddr) ? `DDS_RESP_OK : `DDS_RESP_ERR;
            end
            if (o_s_axi_rvalid & i_s_axi_rready) begin
                o_s_axi_rvalid <= 1'b0;
                o_s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // time base
    // ----------------------------------------
    reg [31:0] tick_cnt_reg;
    reg [15:0] ms_cnt_reg;
    reg [15:0] save_cnt_reg;
    wire ms_tick = (tick_cnt_reg == TICK_CYC - 1);
    wire sec_tick = ms_tick & (ms_cnt_reg == SEC_MS - 1);
    always @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_reg <= 32'h0;
            ms_cnt_reg <= 16'h0;
        end else begin
            tick_cnt_reg <= ms_tick ? 32'h0 : tick_cnt_reg + 32'h1;
            if (ms_tick) ms_cnt_reg <= (ms_cnt_reg == SEC_MS - 1) ? 16'h0 : ms_cnt_reg + 16'h1;
        end
    end

    // ----------------------------------------
    // reversing status and reclose delay
    // ----------------------------------------
    reg [31:0] dly_cnt_reg;
    always @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_reversing_status_out <= 1'b0;
            o_close_enable <= 1'b0;
            dly_cnt_reg <= 32'h0;
        end else begin
            o_reversing_status_out <= rev_src & (dcc | (i_parked_open & park_rpt));
            // delay setting in seconds
            // counted in cycles from the reopen, so the shared tick cannot cut it short
            if (i_reopen_done & i_reopen_full & int_rev & dcc)
                dly_cnt_reg <= dly_s * TICK_CYC * SEC_MS;
            else if (dly_cnt_reg != 32'h0)
                dly_cnt_reg <= dly_cnt_reg - 32'h1;
            o_close_enable <= ~o_door_stop & ~(i_reopen_done & i_reopen_full & int_rev & dcc
                              & (dly_s != 3'h0)) & ((dly_cnt_reg == 32'h0) |
                              (i_reopen_done & ~i_reopen_full));
        end
    end

    // ----------------------------------------
    // clutch retry sequencer
    // ----------------------------------------
    reg [31:0] wait_cyc_reg;
    always @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            cl_state_reg <= ST_IDLE;
            cl_target_reg <= 1'b1;
            retry_reg <= 2'h0;
            wait_cyc_reg <= 32'h0;
            o_clutch_jam_warning <= 1'b0;
            o_warning_code <= 4'h0;
            o_clutch_drive <= 1'b0;
            o_clutch_lock <= 1'b1;
            o_door_closed_status_out <= 1'b0;
        end else begin
            case (cl_state_reg)
                ST_IDLE, ST_STOP: begin
                    if (i_unlock_req | i_lock_req) begin
                        cl_target_reg <= i_lock_req;
                        retry_reg <= 2'h0;
                        o_clutch_jam_warning <= 1'b0;
                        o_warning_code <= 4'h0;
                        cl_state_reg <= ST_MOVE;
                    end
                end
                ST_MOVE: begin
                    if (i_clutch_jam) begin
                        o_clutch_jam_warning <= 1'b1;
                        o_warning_code <= `DDS_WARN_JAM;
                        if (retry_reg == `DDS_RETRY_MAX) cl_state_reg <= ST_STOP;
                        else cl_state_reg <= ST_BACK;
                    end else if (i_clutch_done) begin
                        cl_state_reg <= ST_IDLE;
                    end
                end
                ST_BACK: begin
                    if (i_clutch_done) begin
                        wait_cyc_reg <= 32'h0;
                        cl_state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // retry one second after the reverse move (relock or unlock) ends, not on the shared tick
                    wait_cyc_reg <= wait_cyc_reg + 32'h1;
                    if (wait_cyc_reg == TICK_CYC * SEC_MS * `DDS_RETRY_S - 1) begin
                        retry_reg <= retry_reg + 2'h1;
                        cl_state_reg <= ST_MOVE;
                    end
                end
                default: cl_state_reg <= ST_IDLE;
            endcase
            o_clutch_drive <= (cl_state_reg == ST_MOVE) | (cl_state_reg == ST_BACK);
            // stopped after the last try the clutch is left where the sequence ends
            o_clutch_lock <= (cl_state_reg == ST_BACK) ? ~cl_target_reg : cl_target_reg;
            if (~cl_target_reg & (retry_reg != 2'h0 | cl_state_reg == ST_BACK
                                  | cl_state_reg == ST_WAIT) & (cl_state_reg != ST_IDLE))
                o_door_closed_status_out <= toggle & ((cl_state_reg == ST_BACK) |
                                                      (cl_state_reg == ST_WAIT));
            else
                o_door_closed_status_out <= i_door_closed;
        end
    end

    // ----------------------------------------
    // thermal estimate and limits
    // ----------------------------------------
    reg init_reg;
    wire [23:0] cur_sq = i_motor_current * i_motor_current;
    wire [19:0] heat = cur_sq[23:12] * therm_reg[7:0];
    wire signed [20:0] diff = $signed({5'h0, heat[19:4]}) - $signed({5'h0, temp_reg})
                              + $signed({5'h0, `DDS_T_AMBIENT});
    wire signed [20:0] step = diff >>> therm_reg[11:8];
    wire signed [20:0] sum = $signed({5'h0, temp_reg}) + step;
    always @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            init_reg <= 1'b1;
            temp_reg <= `DDS_T_AMBIENT;
            saved_reg <= 16'h0;
            save_cnt_reg <= 16'h0;
            o_nv_write <= 1'b0;
            o_nv_wdata <= 16'h0;
            o_auxiliary_output <= 1'b0;
            o_speed_reduce <= 1'b0;
            o_door_stop <= 1'b0;
            irq_set <= {`DDS_IRQ_W{1'b0}};
        end else begin
            o_nv_write <= 1'b0;
            if (init_reg & ms_tick) begin
                // restore waits one tick so software can set the store option first
                // start at the saved temperature when storage is on, else at 25 C
                temp_reg <= store_en ? i_nv_temp : `DDS_T_AMBIENT;
                init_reg <= 1'b0;
            end else if (ms_tick & ~init_reg) begin
                temp_reg <= sum[20] ? 16'h0 : (|sum[19:16] ? 16'hffff : sum[15:0]);
            end
            if (sec_tick) save_cnt_reg <= (save_cnt_reg == SAVE_S - 1) ? 16'h0
                                          : save_cnt_reg + 16'h1;
            if (sec_tick & (save_cnt_reg == SAVE_S - 1) & store_en & ~init_reg) begin
                o_nv_write <= 1'b1;
                o_nv_wdata <= temp_reg;
                saved_reg <= temp_reg;
            end
            o_auxiliary_output <= (aux_fn == `DDS_AUX_TEMP_FN) & (temp_reg > `DDS_T_AUX);
            o_speed_reduce <= temp_reg > `DDS_T_SLOW;
            if (temp_reg > `DDS_T_STOP) o_door_stop <= 1'b1;
            else if (temp_reg <= `DDS_T_RECOVER) o_door_stop <= 1'b0;
            irq_set <= {sec_tick & (save_cnt_reg == SAVE_S - 1) & store_en & ~init_reg,
                        ~o_door_stop & (temp_reg > `DDS_T_STOP),
                        ~o_speed_reduce & (temp_reg > `DDS_T_SLOW),
                        ~o_auxiliary_output & (aux_fn == `DDS_AUX_TEMP_FN)
                        & (temp_reg > `DDS_T_AUX),
                        (cl_state_reg == ST_MOVE) & i_clutch_jam};
        end
    end

endmodule // dds_supervisor
`default_nettype wire
